// ===== design/fhr_defines.svh
// Offsets, field positions and timing constants of the floppy host register block.
`ifndef FHR_DEFINES_SVH
`define FHR_DEFINES_SVH
`define FHR_IDX_DOC 3'h2
`define FHR_IDX_TAPE 3'h3
`define FHR_IDX_MSR 3'h4
`define FHR_IDX_DATA 3'h5
`define FHR_IDX_ST0 3'h6
`define FHR_IDX_CFG 3'h7
`define FHR_DOC_RESET 2
`define FHR_DOC_GATE 3
`define FHR_DOC_MOTOR_A 4
`define FHR_DOC_MOTOR_B 5
`define FHR_DRS_SOFT 7
`define FHR_DRS_POWER 6
`define FHR_CFG_THREE 0
`define FHR_CFG_PIO 3
`define FHR_CFG_FM 4
`define FHR_OP_SETUP 5'h13
`define FHR_OP_RECAL 5'h07
`define FHR_OP_SEEK 5'h0f
`define FHR_OP_SENSE 5'h08
`define FHR_OP_READ 5'h06
`define FHR_OP_WRITE 5'h05
`define FHR_TC_NORMAL 2'h0
`define FHR_TC_ABNORMAL 2'h1
`define FHR_TC_INVALID 2'h2
`define FHR_MAX_STEPS 7'h4d
`define FHR_RATE_FAST 2'h3
`define FHR_STEP_US 3000
`define FHR_CLK_MHZ 125
`define FHR_STEP_CYCLES (`FHR_STEP_US * `FHR_CLK_MHZ)
`define FHR_RES_LEN_XFER 3'h7
`define FHR_RES_LEN_SENSE 3'h2
`define FHR_RES_LEN_ONE 3'h1
`endif

// ===== design/fhr_pkg.sv
// Types shared by the floppy host register block.
package fhr_pkg;
  typedef enum logic [2:0] {
    FHR_ST_CMD = 3'h1,
    FHR_ST_EXEC = 3'h2,
    FHR_ST_RES = 3'h4
  } fhr_state_t;
  typedef enum logic [1:0] {
    FHR_MODE_A = 2'h0,
    FHR_MODE_B = 2'h1,
    FHR_MODE_C = 2'h2
  } fhr_mode_t;
endpackage

// ===== design/fhr_top.sv
// Floppy controller host registers with command engine on a classic Wishbone slave.
`timescale 1ns/1ps
`include "fhr_defines.svh"
module fhr_top
  import fhr_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `FHR_STEP_CYCLES,
  parameter logic [7:0] CFG_RESET = 8'h00
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [4:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic track_zero_in_n,
  input wire logic drive_fault_in,
  input wire logic drive_ready_in,
  input wire logic xfer_done_in,
  output logic motor_a_out_n,
  output logic step_out_n,
  output logic dir_out,
  output logic irq_out,
  output logic dma_enable_out,
  output logic low_power_out,
  output logic [1:0] rate_select_out,
  output logic fm_mode_out,
  output logic rate_illegal_out
);

  function automatic logic [3:0] fhr_cmd_len(input logic [4:0] op);
    case (op)
      `FHR_OP_SETUP: fhr_cmd_len = 4'h4;
      `FHR_OP_RECAL: fhr_cmd_len = 4'h2;
      `FHR_OP_SEEK: fhr_cmd_len = 4'h3;
      `FHR_OP_READ, `FHR_OP_WRITE: fhr_cmd_len = 4'h9;
      default: fhr_cmd_len = 4'h1;
    endcase
  endfunction

  function automatic logic [7:0] fhr_st0(input logic [1:0] tc, input logic seek_done,
    input logic equipment_fault, input logic drive_not_ready, input logic [2:0] head_unit);
    fhr_st0 = {tc, seek_done, equipment_fault, drive_not_ready, head_unit};
  endfunction

  // Drive pins arrive from outside and pass two flip-flops first.
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic motor_a_on;
  logic motor_b_on;
  logic dma_irq_gate;
  logic doc_reset;
  logic [1:0] tape_unit_pick;
  logic soft_restart;
  logic low_power_req;
  logic [1:0] rate_select;
  logic [7:0] cfg;
  fhr_state_t state;
  logic [3:0] cmd_cnt;
  logic [7:0] cmd_buf [0:8];
  logic [7:0] res_buf [0:6];
  logic [2:0] res_len;
  logic [2:0] res_idx;
  logic command_active;
  logic unit0_seeking;
  logic seek_pend;
  logic irq_pend;
  logic fifo_en;
  logic [7:0] seek_st0;
  logic [7:0] st0_last;
  logic [7:0] pcn;
  logic [6:0] step_cnt;
  logic [23:0] step_div;

  wire track_zero = !pin_sync[3];
  wire drive_fault = pin_sync[2];
  wire drive_ready = pin_sync[1];
  wire xfer_done = pin_sync[0];
  wire acc = wb_cyc_in && wb_stb_in && wb_ack_out;
  wire wr = acc && wb_we_in && wb_sel_in[0];
  wire rd = acc && !wb_we_in;
  wire [2:0] idx = wb_adr_in[4:2];
  wire doc_wr = wr && idx == `FHR_IDX_DOC;
  wire tape_wr = wr && idx == `FHR_IDX_TAPE;
  wire drs_wr = wr && idx == `FHR_IDX_MSR;
  wire cfg_wr = wr && idx == `FHR_IDX_CFG;
  wire data_wr = wr && idx == `FHR_IDX_DATA;
  wire data_rd = rd && idx == `FHR_IDX_DATA;
  wire ctrl_rst = !resetn_in || !doc_reset || soft_restart;
  wire three_mode = cfg[`FHR_CFG_THREE];
  wire [1:0] cfg_mode = cfg[2:1];
  wire pio_mode = cfg[`FHR_CFG_PIO];
  wire [1:0] drive_type_code = cfg[6:5];
  wire mode_b = cfg_mode == FHR_MODE_B;
  wire gate_eff = mode_b || dma_irq_gate;
  wire host_xfer_ready = !ctrl_rst && (state == FHR_ST_CMD || state == FHR_ST_RES);
  wire xfer_direction = state == FHR_ST_RES;
  wire [7:0] msr = {host_xfer_ready, xfer_direction, pio_mode, command_active,
                    3'h0, unit0_seeking};
  wire [7:0] doc_rd = {2'h0, motor_b_on, motor_a_on, dma_irq_gate && !mode_b, doc_reset, 2'h3};
  wire [1:0] tape_hi = three_mode ? drive_type_code : 2'h3;
  wire [1:0] tape_mid = three_mode ? 2'h0 : 2'h3;
  wire [7:0] tape_rd = {2'h0, tape_hi, tape_mid, tape_unit_pick};
  wire [7:0] data_out = host_xfer_ready && xfer_direction ? res_buf[res_idx] : 8'h00;
  wire [4:0] op = cmd_buf[0][4:0];
  wire [4:0] cur_op = cmd_cnt == 4'h0 ? wb_dat_in[4:0] : op;
  wire byte_last = cmd_cnt + 4'h1 == fhr_cmd_len(cur_op);
  wire [2:0] head_unit = {cmd_buf[1][2], cmd_buf[1][1:0]};
  wire is_seek = op == `FHR_OP_RECAL || op == `FHR_OP_SEEK;
  wire step_tick = step_div == 24'(STEP_CYCLES - 1);
  wire recal_end = op == `FHR_OP_RECAL && (track_zero || step_cnt == `FHR_MAX_STEPS);
  wire seek_end = op == `FHR_OP_SEEK && pcn == cmd_buf[2];
  wire step_fire = state == FHR_ST_EXEC && is_seek && step_tick && !recal_end && !seek_end;
  wire step_dir = op == `FHR_OP_SEEK && cmd_buf[2] > pcn;
  wire rate_illegal = cfg[`FHR_CFG_FM] && rate_select == `FHR_RATE_FAST;
  wire xfer_stop = xfer_done || drive_fault || !drive_ready;
  wire [1:0] xfer_tc = xfer_done && drive_ready && !drive_fault ? `FHR_TC_NORMAL
                                                                 : `FHR_TC_ABNORMAL;
  wire [7:0] xfer_st0 = fhr_st0(xfer_tc, 1'b0, drive_fault, !drive_ready, head_unit);
  wire recal_fail = op == `FHR_OP_RECAL && !track_zero;
  wire [7:0] end_st0 = fhr_st0(recal_fail ? `FHR_TC_ABNORMAL : `FHR_TC_NORMAL, 1'b1,
                               recal_fail || drive_fault, !drive_ready, head_unit);
  wire [7:0] bad_st0 = fhr_st0(`FHR_TC_INVALID, 1'b0, 1'b0, 1'b0, 3'h0);
  wire [7:0] rd_mux = idx == `FHR_IDX_DOC ? doc_rd :
                      idx == `FHR_IDX_TAPE ? tape_rd :
                      idx == `FHR_IDX_MSR ? msr :
                      idx == `FHR_IDX_DATA ? data_out :
                      idx == `FHR_IDX_ST0 ? st0_last :
                      idx == `FHR_IDX_CFG ? {rate_illegal, cfg[6:0]} : 8'h00;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pin_meta <= 4'h8;
      pin_sync <= 4'h8;
    end else begin
      pin_meta <= {track_zero_in_n, drive_fault_in, drive_ready_in, xfer_done_in};
      pin_sync <= pin_meta;
    end
  end

  // The slave answers one cycle after the request; accesses act on the ack edge.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
      wb_dat_out <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      motor_a_on <= 1'b0;
      motor_b_on <= 1'b0;
      dma_irq_gate <= 1'b0;
      doc_reset <= 1'b0;
      tape_unit_pick <= 2'h0;
      low_power_req <= 1'b0;
      rate_select <= 2'h0;
      soft_restart <= 1'b0;
      cfg <= CFG_RESET;
    end else begin
      if (doc_wr) begin
        motor_a_on <= wb_dat_in[`FHR_DOC_MOTOR_A];
        motor_b_on <= wb_dat_in[`FHR_DOC_MOTOR_B];
        dma_irq_gate <= wb_dat_in[`FHR_DOC_GATE];
        doc_reset <= wb_dat_in[`FHR_DOC_RESET];
      end
      if (tape_wr) begin
        tape_unit_pick <= wb_dat_in[1:0];
      end
      if (drs_wr) begin
        low_power_req <= wb_dat_in[`FHR_DRS_POWER];
        rate_select <= wb_dat_in[1:0];
      end
      // A fresh write wins over the self clear, so a restart is never lost.
      soft_restart <= drs_wr && wb_dat_in[`FHR_DRS_SOFT];
      if (cfg_wr) begin
        cfg <= {1'b0, wb_dat_in[6:0]};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      motor_a_out_n <= 1'b1;
      step_out_n <= 1'b1;
      dir_out <= 1'b0;
      irq_out <= 1'b0;
      dma_enable_out <= 1'b0;
      low_power_out <= 1'b0;
      rate_select_out <= 2'h0;
      fm_mode_out <= 1'b0;
      rate_illegal_out <= 1'b0;
    end else begin
      motor_a_out_n <= !motor_a_on;
      step_out_n <= !step_fire;
      dir_out <= step_dir;
      irq_out <= irq_pend && gate_eff;
      dma_enable_out <= gate_eff && !pio_mode && fifo_en;
      low_power_out <= low_power_req;
      rate_select_out <= rate_select;
      fm_mode_out <= cfg[`FHR_CFG_FM];
      rate_illegal_out <= rate_illegal;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in || state != FHR_ST_EXEC || !is_seek || step_tick) begin
      step_div <= 24'h00_0000;
    end else begin
      step_div <= step_div + 24'h00_0001;
    end
  end

  // Command engine: command bytes in, execution, then result bytes out, except after setup, recalibrate and seek.
  always_ff @(posedge clk_in) begin
    if (ctrl_rst) begin
      state <= FHR_ST_CMD;
      cmd_cnt <= 4'h0;
      res_idx <= 3'h0;
      res_len <= 3'h0;
      command_active <= 1'b0;
      unit0_seeking <= 1'b0;
      seek_pend <= 1'b0;
      irq_pend <= 1'b0;
      fifo_en <= 1'b0;
      seek_st0 <= 8'h00;
      st0_last <= 8'h00;
      pcn <= 8'h00;
      step_cnt <= 7'h00;
    end else begin
      case (state)
        FHR_ST_CMD: begin
          if (data_wr) begin
            cmd_buf[cmd_cnt] <= wb_dat_in[7:0];
            cmd_cnt <= byte_last ? 4'h0 : cmd_cnt + 4'h1;
            if (cmd_cnt == 4'h0) begin
              irq_pend <= 1'b0;
              command_active <= cur_op == `FHR_OP_READ || cur_op == `FHR_OP_WRITE;
            end
            if (byte_last) begin
              state <= FHR_ST_EXEC;
              step_cnt <= 7'h00;
            end
          end
        end
        FHR_ST_EXEC: begin
          case (op)
            `FHR_OP_SETUP: begin
              fifo_en <= 1'b1;
              state <= FHR_ST_CMD;
            end
            `FHR_OP_RECAL, `FHR_OP_SEEK: begin
              unit0_seeking <= 1'b1;
              if (step_tick && (recal_end || seek_end)) begin
                unit0_seeking <= 1'b0;
                seek_pend <= 1'b1;
                irq_pend <= 1'b1;
                seek_st0 <= end_st0;
                st0_last <= end_st0;
                pcn <= recal_fail ? pcn : (op == `FHR_OP_RECAL ? 8'h00 : pcn);
                state <= FHR_ST_CMD;
              end else if (step_fire) begin
                step_cnt <= step_cnt + 7'h01;
                pcn <= op == `FHR_OP_RECAL ? pcn : (step_dir ? pcn + 8'h01 : pcn - 8'h01);
              end
            end
            `FHR_OP_SENSE: begin
              res_buf[0] <= seek_pend ? seek_st0 : bad_st0;
              res_buf[1] <= pcn;
              res_len <= seek_pend ? `FHR_RES_LEN_SENSE : `FHR_RES_LEN_ONE;
              st0_last <= seek_pend ? seek_st0 : bad_st0;
              seek_pend <= 1'b0;
              state <= FHR_ST_RES;
            end
            `FHR_OP_READ, `FHR_OP_WRITE: begin
              if (xfer_stop) begin
                res_buf[0] <= xfer_st0;
                res_buf[1] <= 8'h00;
                res_buf[2] <= 8'h00;
                res_buf[3] <= cmd_buf[2];
                res_buf[4] <= cmd_buf[3];
                res_buf[5] <= cmd_buf[4];
                res_buf[6] <= cmd_buf[5];
                res_len <= `FHR_RES_LEN_XFER;
                st0_last <= xfer_st0;
                irq_pend <= 1'b1;
                state <= FHR_ST_RES;
              end
            end
            default: begin
              res_buf[0] <= bad_st0;
              res_len <= `FHR_RES_LEN_ONE;
              st0_last <= bad_st0;
              state <= FHR_ST_RES;
            end
          endcase
        end
        FHR_ST_RES: begin
          if (data_rd) begin
            irq_pend <= 1'b0;
            if (res_idx + 3'h1 == res_len) begin
              res_idx <= 3'h0;
              command_active <= 1'b0;
              state <= FHR_ST_CMD;
            end else begin
              res_idx <= res_idx + 3'h1;
            end
          end
        end
        default: state <= FHR_ST_CMD;
      endcase
    end
  end

  motor_pin_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(motor_a_on) |=> !motor_a_out_n) else $error("motor pin did not follow bit");
  gate_off_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!mode_b && !dma_irq_gate) |=> (!irq_out && !dma_enable_out))
    else $error("gating off but outputs on");
  mode_b_irq_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode_b && irq_pend) |=> irq_out) else $error("mode b interrupt blocked");
  reset_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!doc_reset ##1 !doc_reset) |-> (state == FHR_ST_CMD && !msr[7]))
    else $error("controller left reset");
  tape_field_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    three_mode |-> (tape_rd[7:2] == {2'h0, drive_type_code, 2'h0}))
    else $error("tape field wrong in three mode");
  soft_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (soft_restart && !drs_wr) |=> (!soft_restart && state == FHR_ST_CMD))
    else $error("soft restart stuck");
  cmd_to_exec_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!ctrl_rst && state == FHR_ST_CMD && data_wr && byte_last) |=> state == FHR_ST_EXEC)
    else $error("last byte did not start execution");
  result_dir_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == FHR_ST_RES && !ctrl_rst) |-> (msr[7:6] == 2'h3))
    else $error("result phase direction wrong");
  step_limit_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!ctrl_rst && state == FHR_ST_EXEC && op == `FHR_OP_RECAL && step_tick
     && step_cnt == `FHR_MAX_STEPS && !track_zero) |=> seek_st0[4])
    else $error("step limit fault missing");
  busy_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!ctrl_rst && state == FHR_ST_CMD && data_wr && cmd_cnt == 4'h0
     && wb_dat_in[4:0] == `FHR_OP_READ) |=> msr[4])
    else $error("busy not set for read");

endmodule

// ===== tb/fhr_host_bfm.sv
// Host processor model that issues classic single Wishbone register accesses.
`timescale 1ns/1ps
module fhr_host_bfm (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic [31:0] dat_in,
  output logic cyc_out,
  output logic stb_out,
  output logic we_out,
  output logic [4:0] adr_out,
  output logic [3:0] sel_out,
  output logic [31:0] dat_out,
  output logic hung_out
);
  initial begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out = 1'b0;
    adr_out = 5'h00;
    sel_out = 4'h0;
    dat_out = 32'h0000_0000;
    hung_out = 1'b0;
  end

  // Entered just after a rising edge; the request stands until ack is sampled high or 50 edges pass.
  task automatic access(input logic we, input logic [2:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
    int n;
    n = 0;
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= we;
    adr_out <= {idx, 2'b00};
    sel_out <= 4'h1;
    dat_out <= {24'h00_0000, wd};
    do begin
      @(posedge clk_in);
      n++;
    end while (ack_in !== 1'b1 && n < 50);
    if (n >= 50) begin
      hung_out <= 1'b1;
    end
    rd = dat_in[7:0];
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    @(posedge clk_in);
  endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the floppy host register block.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
  logic clk_in, resetn_in, cyc, stb, we, ack, tz_n, fault, ready, xdone, hung;
  logic motor_n, step_n, dir, irq, dma, lp, fm, illegal;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  logic [1:0] rate;
  logic [7:0] s;
  int errors = 0;
  int cmp_count = 0;
  int steps = 0;
  int ins = 0;

  fhr_top #(.STEP_CYCLES(8)) i_fhr_top (
    .clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w),
    .wb_dat_out(dat_r), .wb_ack_out(ack), .track_zero_in_n(tz_n),
    .drive_fault_in(fault), .drive_ready_in(ready), .xfer_done_in(xdone),
    .motor_a_out_n(motor_n), .step_out_n(step_n), .dir_out(dir), .irq_out(irq),
    .dma_enable_out(dma), .low_power_out(lp), .rate_select_out(rate),
    .fm_mode_out(fm), .rate_illegal_out(illegal));

  fhr_host_bfm i_fhr_host_bfm (
    .clk_in(clk_in), .ack_in(ack), .dat_in(dat_r), .cyc_out(cyc), .stb_out(stb),
    .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(dat_w), .hung_out(hung));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // Each step is one low cycle, so it is counted once at the edge that ends it.
  always @(posedge clk_in) begin
    if (step_n === 1'b0) begin
      steps++;
      if (dir === 1'b1) begin
        ins++;
      end
    end
  end

  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [7:0] x;
    i_fhr_host_bfm.access(1'b1, idx, d, x);
    // Two more edges let a written bit reach the output flops before a check reads them.
    repeat (2) @(posedge clk_in);
  endtask

  task automatic rd(input logic [2:0] idx, output logic [7:0] d);
    i_fhr_host_bfm.access(1'b0, idx, 8'h00, d);
  endtask

  task automatic end_of_test();
    if (hung) begin
      errors++;
    end
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Bytes move only once the status shows the controller ready and idle.
  task automatic wait_idle();
    int n;
    n = 0;
    s = 8'h01;
    while (s[0] !== 1'b0 || s[7] !== 1'b1) begin
      rd(3'h4, s);
      n++;
      if (n > 400) begin
        errors++;
        end_of_test();
      end
    end
  endtask

  task automatic t_reset();
    rd(3'h0, s);
    `CHK(s, 8'h00)
    rd(3'h2, s);
    `CHK(s, 8'h03)
    `CHK(motor_n, 1'b1)
    rd(3'h3, s);
    `CHK(s, 8'h3c)
    rd(3'h4, s);
    `CHK(s, 8'h00)
    $display("test reset done");
  endtask

  task automatic t_control();
    wr(3'h2, 8'h1c);
    `CHK(motor_n, 1'b0)
    rd(3'h2, s);
    `CHK(s, 8'h1f)
    rd(3'h4, s);
    `CHK(s, 8'h80)
    `CHK(dma, 1'b0)
    wr(3'h5, 8'h13);
    for (int i = 0; i < 3; i++) begin
      wr(3'h5, 8'h00);
    end
    `CHK(dma, 1'b1)
    rd(3'h4, s);
    `CHK(s, 8'h80)
    wr(3'h2, 8'h14);
    `CHK(dma, 1'b0)
    wr(3'h2, 8'h1c);
    $display("test control done");
  endtask

  task automatic t_invalid();
    wr(3'h5, 8'h00);
    rd(3'h4, s);
    `CHK(s, 8'hc0)
    rd(3'h5, s);
    `CHK(s, 8'h80)
    rd(3'h4, s);
    `CHK(s, 8'h80)
    wr(3'h5, 8'h00);
    wr(3'h4, 8'h80);
    rd(3'h4, s);
    `CHK(s, 8'h80)
    `CHK(dma, 1'b0)
    $display("test invalid done");
  endtask

  task automatic t_recal();
    steps = 0;
    wr(3'h5, 8'h07);
    wr(3'h5, 8'h00);
    rd(3'h4, s);
    `CHK(s[0], 1'b1)
    wait_idle();
    `CHK(steps, 77)
    `CHK(irq, 1'b1)
    wr(3'h2, 8'h14);
    `CHK(irq, 1'b0)
    wr(3'h2, 8'h1c);
    wr(3'h5, 8'h08);
    rd(3'h5, s);
    `CHK(s & 8'hd0, 8'h50)
    rd(3'h5, s);
    tz_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    wr(3'h5, 8'h07);
    wr(3'h5, 8'h00);
    wait_idle();
    wr(3'h5, 8'h08);
    rd(3'h5, s);
    `CHK(s, 8'h20)
    rd(3'h5, s);
    `CHK(s, 8'h00)
    steps = 0;
    ins = 0;
    wr(3'h5, 8'h0f);
    wr(3'h5, 8'h00);
    wr(3'h5, 8'h03);
    wait_idle();
    `CHK(steps, 3)
    `CHK(ins, 3)
    wr(3'h5, 8'h08);
    rd(3'h5, s);
    `CHK(s, 8'h20)
    rd(3'h5, s);
    `CHK(s, 8'h03)
    $display("test recal done");
  endtask

  task automatic t_read();
    logic [7:0] cmd [9] = '{8'h06, 8'h05, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77};
    logic [7:0] res [7] = '{8'h05, 8'h00, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44};
    foreach (cmd[i]) wr(3'h5, cmd[i]);
    rd(3'h4, s);
    `CHK(s & 8'h10, 8'h10)
    xdone <= 1'b1;
    @(posedge clk_in);
    xdone <= 1'b0;
    @(posedge clk_in);
    repeat (2) @(posedge clk_in);
    rd(3'h4, s);
    `CHK(s, 8'hd0)
    foreach (res[i]) begin
      rd(3'h5, s);
      `CHK(s, res[i])
    end
    ready <= 1'b0;
    wr(3'h5, 8'h05);
    repeat (8) wr(3'h5, 8'h00);
    rd(3'h4, s);
    `CHK(s, 8'hd0)
    rd(3'h5, s);
    `CHK(s, 8'h48)
    repeat (6) rd(3'h5, s);
    ready <= 1'b1;
    rd(3'h6, s);
    `CHK(s, 8'h48)
    $display("test read done");
  endtask

  task automatic t_rate();
    wr(3'h4, 8'h43);
    `CHK(lp, 1'b1)
    `CHK(rate, 2'h3)
    `CHK(illegal, 1'b0)
    wr(3'h7, 8'h10);
    `CHK(fm, 1'b1)
    `CHK(illegal, 1'b1)
    wr(3'h4, 8'h01);
    `CHK(illegal, 1'b0)
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h02);
    wr(3'h7, 8'h41);
    rd(3'h3, s);
    `CHK(s, 8'h22)
    wr(3'h7, 8'h00);
    rd(3'h3, s);
    `CHK(s, 8'h3e)
    wr(3'h7, 8'h08);
    rd(3'h4, s);
    `CHK(s, 8'ha0)
    wr(3'h7, 8'h02);
    wr(3'h2, 8'h14);
    rd(3'h2, s);
    `CHK(s, 8'h17)
    wr(3'h5, 8'h13);
    repeat (3) wr(3'h5, 8'h00);
    `CHK(dma, 1'b1)
    wr(3'h5, 8'h07);
    wr(3'h5, 8'h00);
    wait_idle();
    `CHK(irq, 1'b1)
    $display("test rate and config done");
  endtask

  initial begin
    resetn_in = 1'b0;
    tz_n = 1'b1;
    fault = 1'b0;
    ready = 1'b1;
    xdone = 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_control();
    t_invalid();
    t_recal();
    t_read();
    t_rate();
    end_of_test();
  end
endmodule
